// ---- inc/pms_pkg.sv ----
package pms_pkg;

    // Clock rates
    localparam int REF_HZ    = 20_000_000;
    localparam int MII100_HZ = 25_000_000;
    localparam int MII10_HZ  = 2_500_000;
    localparam int SER10_HZ  = 10_000_000;

    // MAC clock half periods in reference cycles, never below one
    localparam int HALF_100_I   = REF_HZ / (2 * MII100_HZ);
    localparam int HALF_M10_I   = REF_HZ / (2 * MII10_HZ);
    localparam int HALF_S10_I   = REF_HZ / (2 * SER10_HZ);
    localparam logic [7:0] HALF_100 = (HALF_100_I < 1) ? 8'h01 : 8'(HALF_100_I);
    localparam logic [7:0] HALF_M10 = (HALF_M10_I < 1) ? 8'h01 : 8'(HALF_M10_I);
    localparam logic [7:0] HALF_S10 = (HALF_S10_I < 1) ? 8'h01 : 8'(HALF_S10_I);

    // Strap capture delay after reset release
    localparam logic [1:0] CAP_DELAY = 2'h2;
    localparam logic [4:0] ADDR_TRISTATE = 5'h00;

    // Line code groups
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_J    = 5'h18;
    localparam logic [4:0] SYM_K    = 5'h11;
    localparam logic [4:0] SYM_T    = 5'h0D;
    localparam logic [4:0] SYM_R    = 5'h07;
    localparam logic [4:0] SYM_H    = 5'h04;
    localparam logic [3:0] PREAMBLE_NIB = 4'h5;

    // Register map
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STAT   = 4'h1;
    localparam logic [7:0] CTRL_RST   = 8'h07;
    localparam logic [7:0] CTRL_MASK  = 8'h07;
    localparam int CTRL_SPEED_BIT = 0;
    localparam int CTRL_DUPLEX_BIT = 1;
    localparam int CTRL_AN_BIT    = 2;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_K    = 2'b01,
        TX_DATA = 2'b10,
        TX_END  = 2'b11
    } pms_tx_t;

    // Inputs from outside the clock domain, synchronised as one vector
    typedef struct packed {
        logic [4:0] addr;
        logic       an;
        logic       dup;
        logic       spd;
        logic       hwsw;
        logic       rep;
        logic       ser;
        logic       pan;
        logic       lock;
        logic       link;
        logic       act;
        logic       lclk;
        logic [4:0] sym;
    } pms_pins_t;

    function automatic logic [4:0] pms_enc(input logic [3:0] n);
        logic [4:0] t [16];
        t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
              5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
        return t[n];
    endfunction

    // Returns {hit, nibble}
    function automatic logic [4:0] pms_dec(input logic [4:0] s);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (pms_enc(4'(i)) == s) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic pms_is_ctrl(input logic [4:0] s);
        return (s == SYM_IDLE) || (s == SYM_J) || (s == SYM_K) ||
               (s == SYM_T) || (s == SYM_R) || (s == SYM_H);
    endfunction

endpackage

// ---- hdl/pms_mac_side.sv ----
// How it works
// - Interface strap high selects stream/serial, low MII
// - Drive MAC clocks at mode dependent rate
// - Receive outputs change with generated receive clock
// - Encode nibbles into five bit code groups
// - Pulse receive error per invalid group
// - Error signals only used at 100 Mb/s
// - Transmit error sends halt symbols; hold low
// - Stream mode passes symbols unchanged both ways
// - Carrier sense during transmit or receive
// - Collision only half duplex, both active
// - Repeater strap changes carrier sense behaviour
// - Config pins inputs in hardware, outputs software
// - Hardware fixed link from speed, duplex
// - Hardware negotiation advertises single combination
// - Non negotiating partner gives half duplex
// - Software mode drives speed, duplex, negotiation status
// - Link status high while link valid
// - Lock high while receive PLL locked
// - Strapless variant: node, software, negotiation on
// - Zero address tristates receive data, clocks
`timescale 1ns/1ps
module pms_mac_side
    import pms_pkg::*;
#(
    parameter bit HAS_STRAPS = 1'b1
) (
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RSTN,
    input  wire logic       I_IFACE_SERIAL_SEL,
    input  wire logic       I_REPEATER_SEL,
    input  wire logic       I_HARDWARE_SOFTWARE_CONFIG_SELECT,
    input  wire logic [4:0] I_PHY_ADDR,
    input  wire logic       I_SPEED_SELECT,
    input  wire logic       I_DUPLEX_SELECT,
    input  wire logic       I_AUTONEG_SELECT,
    output logic            O_SPEED_SELECT,
    output logic            O_SPEED_SELECT_OE,
    output logic            O_DUPLEX_SELECT,
    output logic            O_DUPLEX_SELECT_OE,
    output logic            O_AUTONEG_SELECT,
    output logic            O_AUTONEG_SELECT_OE,
    output logic            O_TX_CLK,
    output logic            O_TX_CLK_OE,
    output logic            O_RX_CLK,
    output logic            O_RX_CLK_OE,
    input  wire logic       I_TX_EN,
    input  wire logic       I_TX_ER,
    input  wire logic [4:0] I_TX_DATA,
    output logic            O_RX_DV,
    output logic            O_RX_ER,
    output logic [4:0]      O_RX_DATA,
    output logic            O_RX_DATA_OE,
    output logic            O_CRS,
    output logic            O_COL,
    input  wire logic       I_LINE_CLK,
    input  wire logic [4:0] I_LINE_RX_SYM,
    input  wire logic       I_LINE_RX_ACT,
    input  wire logic       I_LINE_LINK_OK,
    input  wire logic       I_LINE_PLL_LOCK,
    input  wire logic       I_PARTNER_AN,
    output logic [4:0]      O_LINE_TX_SYM,
    output logic            O_LINE_TX_VALID,
    output logic            O_AN_ENABLE,
    output logic [1:0]      O_AN_ADVERTISE,
    output logic            O_LINK_STATUS_OUT,
    output logic            O_PLL_LOCK,
    input  wire logic [3:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    output logic [7:0]      O_REG_RDATA
);

    typedef struct packed {
        pms_pins_t  sy1;
        pms_pins_t  sy2;
        logic [1:0] cap_cnt;
        logic       cap_done;
        logic [4:0] addr_cap;
        logic       pin_oe;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic       cfg_spd;
        logic       cfg_dup;
        logic       cfg_an;
        logic       cfg_ser;
        logic       cfg_oe;
        logic [1:0] adv;
        logic [7:0] div_cnt;
        logic       mclk;
        logic       lclk_d;
        logic [4:0] rx_sym;
        logic       rx_new;
        logic       rx_frame;
        logic       rx_dv;
        logic       rx_er;
        logic [4:0] rx_data;
        pms_tx_t    tx_st;
        logic [4:0] tx_sym;
        logic       tx_valid;
        logic       tx_on;
        logic       crs;
        logic       col;
        logic       link;
        logic       lock;
    } pms_state_t;

    pms_state_t st_ff;
    pms_state_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    logic       hw;
    logic       rep;
    logic       rise;
    logic       fall;
    logic [7:0] half;
    logic [4:0] dec;

    assign rst_n = rst_sync_ff[1];

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sy1 = {I_PHY_ADDR, I_AUTONEG_SELECT, I_DUPLEX_SELECT, I_SPEED_SELECT,
                      I_HARDWARE_SOFTWARE_CONFIG_SELECT, I_REPEATER_SEL,
                      I_IFACE_SERIAL_SEL, I_PARTNER_AN, I_LINE_PLL_LOCK, I_LINE_LINK_OK,
                      I_LINE_RX_ACT, I_LINE_CLK, I_LINE_RX_SYM};
        nxt_st.sy2 = st_ff.sy1;

        // Address strap caught once after release
        if (!st_ff.cap_done) begin
            if (st_ff.cap_cnt == CAP_DELAY) begin
                nxt_st.cap_done = 1'b1;
                nxt_st.addr_cap = st_ff.sy2.addr;
                nxt_st.pin_oe   = (st_ff.sy2.addr != ADDR_TRISTATE);
            end else begin
                nxt_st.cap_cnt = st_ff.cap_cnt + 2'h1;
            end
        end

        // Strapless variant runs as node in software mode
        hw  = HAS_STRAPS && !st_ff.sy2.hwsw;
        rep = HAS_STRAPS && st_ff.sy2.rep;
        nxt_st.cfg_ser = HAS_STRAPS && st_ff.sy2.ser;
        nxt_st.cfg_oe  = !hw;
        if (hw) begin
            nxt_st.cfg_an  = st_ff.sy2.an;
            nxt_st.cfg_spd = st_ff.sy2.spd;
            nxt_st.cfg_dup = st_ff.sy2.dup;
        end else begin
            nxt_st.cfg_an  = st_ff.ctrl[CTRL_AN_BIT];
            nxt_st.cfg_spd = st_ff.ctrl[CTRL_SPEED_BIT];
            nxt_st.cfg_dup = st_ff.ctrl[CTRL_DUPLEX_BIT];
        end
        nxt_st.adv = {nxt_st.cfg_spd, nxt_st.cfg_dup};
        if (nxt_st.cfg_an && !st_ff.sy2.pan) begin
            nxt_st.cfg_dup = 1'b0;
        end
        nxt_st.link = st_ff.sy2.link;
        nxt_st.lock = st_ff.sy2.lock;

        // Register port
        nxt_st.rdata = 8'h00;
        if (I_REG_WR && (I_REG_ADDR == REG_CTRL)) begin
            nxt_st.ctrl = I_REG_WDATA & CTRL_MASK;
        end
        if (I_REG_RD) begin
            if (I_REG_ADDR == REG_CTRL) begin
                nxt_st.rdata = st_ff.ctrl;
            end else if (I_REG_ADDR == REG_STAT) begin
                nxt_st.rdata = {st_ff.lock, st_ff.link, rep, st_ff.cfg_ser, hw,
                                st_ff.cfg_an, st_ff.cfg_dup, st_ff.cfg_spd};
            end
        end

        // MAC clock divider
        if (st_ff.cfg_spd) begin
            half = HALF_100;
        end else if (st_ff.cfg_ser) begin
            half = HALF_S10;
        end else begin
            half = HALF_M10;
        end
        rise = 1'b0;
        fall = 1'b0;
        if (st_ff.div_cnt >= half - 8'h01) begin
            nxt_st.div_cnt = 8'h00;
            nxt_st.mclk    = !st_ff.mclk;
            rise = !st_ff.mclk;
            fall = st_ff.mclk;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
        end

        // Line symbol taken at each line clock rising edge
        nxt_st.lclk_d = st_ff.sy2.lclk;
        dec = pms_dec(st_ff.rx_sym);
        if (fall) begin
            nxt_st.rx_er  = 1'b0;
            nxt_st.rx_new = 1'b0;
            if (st_ff.rx_new) begin
                if (st_ff.cfg_spd && st_ff.cfg_ser) begin
                    nxt_st.rx_data = st_ff.rx_sym;
                    nxt_st.rx_dv   = st_ff.sy2.act;
                end else if (st_ff.cfg_spd) begin
                    if (st_ff.rx_sym == SYM_J || st_ff.rx_sym == SYM_K) begin
                        nxt_st.rx_frame = 1'b1;
                        nxt_st.rx_dv    = 1'b1;
                        nxt_st.rx_data  = {1'b0, PREAMBLE_NIB};
                    end else if (dec[4] && st_ff.rx_frame) begin
                        nxt_st.rx_dv   = 1'b1;
                        nxt_st.rx_data = {1'b0, dec[3:0]};
                    end else if (!dec[4] && !pms_is_ctrl(st_ff.rx_sym)) begin
                        nxt_st.rx_er = 1'b1;
                    end else begin
                        nxt_st.rx_frame = 1'b0;
                        nxt_st.rx_dv    = 1'b0;
                    end
                end else if (st_ff.cfg_ser) begin
                    nxt_st.rx_data = {4'h0, st_ff.rx_sym[0]};
                    nxt_st.rx_dv   = st_ff.sy2.act;
                end else begin
                    nxt_st.rx_data = {1'b0, st_ff.rx_sym[3:0]};
                    nxt_st.rx_dv   = st_ff.sy2.act;
                end
            end
        end
        if (st_ff.sy2.lclk && !st_ff.lclk_d) begin
            nxt_st.rx_sym = st_ff.sy2.sym;
            nxt_st.rx_new = 1'b1;
        end

        // Transmit sampled on our own MAC clock rising edge
        if (rise) begin
            nxt_st.tx_on = I_TX_EN;
            if (st_ff.cfg_spd && st_ff.cfg_ser) begin
                nxt_st.tx_sym   = I_TX_DATA;
                nxt_st.tx_valid = 1'b1;
            end else if (st_ff.cfg_spd) begin
                nxt_st.tx_valid = 1'b1;
                unique case (st_ff.tx_st)
                    TX_IDLE: begin
                        nxt_st.tx_sym = I_TX_EN ? SYM_J : SYM_IDLE;
                        nxt_st.tx_st  = I_TX_EN ? TX_K : TX_IDLE;
                    end
                    TX_K: begin
                        nxt_st.tx_sym = SYM_K;
                        nxt_st.tx_st  = TX_DATA;
                    end
                    TX_DATA: begin
                        nxt_st.tx_sym = I_TX_EN ? pms_enc(I_TX_DATA[3:0]) : SYM_T;
                        nxt_st.tx_st  = I_TX_EN ? TX_DATA : TX_END;
                    end
                    TX_END: begin
                        nxt_st.tx_sym = SYM_R;
                        nxt_st.tx_st  = TX_IDLE;
                    end
                endcase
                if (I_TX_ER) begin
                    nxt_st.tx_sym = SYM_H;
                end
            end else begin
                nxt_st.tx_st    = TX_IDLE;
                nxt_st.tx_valid = I_TX_EN;
                nxt_st.tx_sym   = st_ff.cfg_ser ? {4'h0, I_TX_DATA[0]}
                                                : {1'b0, I_TX_DATA[3:0]};
            end
        end

        // Carrier sense and collision; a repeater reports receive only
        nxt_st.crs = st_ff.sy2.act || (st_ff.tx_on && !rep);
        nxt_st.col = !st_ff.cfg_dup && st_ff.tx_on && st_ff.sy2.act;
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_ff        <= '0;
            st_ff.ctrl   <= CTRL_RST;
            st_ff.tx_sym <= SYM_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_SPEED_SELECT      = st_ff.cfg_spd;
    assign O_DUPLEX_SELECT     = st_ff.cfg_dup;
    assign O_AUTONEG_SELECT    = st_ff.cfg_an;
    assign O_SPEED_SELECT_OE   = st_ff.cfg_oe;
    assign O_DUPLEX_SELECT_OE  = st_ff.cfg_oe;
    assign O_AUTONEG_SELECT_OE = st_ff.cfg_oe;
    assign O_TX_CLK            = st_ff.mclk;
    assign O_RX_CLK            = st_ff.mclk;
    assign O_TX_CLK_OE         = st_ff.pin_oe;
    assign O_RX_CLK_OE         = st_ff.pin_oe;
    assign O_RX_DATA_OE        = st_ff.pin_oe;
    assign O_RX_DV             = st_ff.rx_dv;
    assign O_RX_ER             = st_ff.rx_er;
    assign O_RX_DATA           = st_ff.rx_data;
    assign O_CRS               = st_ff.crs;
    assign O_COL               = st_ff.col;
    assign O_LINE_TX_SYM       = st_ff.tx_sym;
    assign O_LINE_TX_VALID     = st_ff.tx_valid;
    assign O_AN_ENABLE         = st_ff.cfg_an;
    assign O_AN_ADVERTISE      = st_ff.adv;
    assign O_LINK_STATUS_OUT   = st_ff.link;
    assign O_PLL_LOCK          = st_ff.lock;
    assign O_REG_RDATA         = st_ff.rdata;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!rst_n);

    rx_at_fall_a: assert property (!$past(fall) |-> $stable(O_RX_DV))
        else $error("rx valid off fall");
    serial_rx_a: assert property (fall && st_ff.rx_new && !st_ff.cfg_spd && st_ff.cfg_ser
        |=> O_RX_DATA == {4'h0, $past(st_ff.rx_sym[0])})
        else $error("serial receive bit wrong");
    tx_encode_a: assert property (rise && st_ff.cfg_spd && !st_ff.cfg_ser
        && st_ff.tx_st == TX_DATA && I_TX_EN && !I_TX_ER
        |=> O_LINE_TX_SYM == pms_enc($past(I_TX_DATA[3:0])))
        else $error("nibble not encoded");
    rx_err_pulse_a: assert property (fall && st_ff.rx_new && st_ff.cfg_spd && !st_ff.cfg_ser
        && !dec[4] && !pms_is_ctrl(st_ff.rx_sym) |=> O_RX_ER)
        else $error("no rx error");
    err_10m_a: assert property (!st_ff.cfg_spd && !$past(st_ff.cfg_spd) |-> !O_RX_ER)
        else $error("receive error at 10 Mb/s");
    tx_halt_a: assert property (rise && st_ff.cfg_spd && !st_ff.cfg_ser && I_TX_ER
        |=> O_LINE_TX_SYM == SYM_H)
        else $error("no halt");
    stream_pass_a: assert property (rise && st_ff.cfg_spd && st_ff.cfg_ser
        |=> O_LINE_TX_SYM == $past(I_TX_DATA))
        else $error("stream symbol altered");
    crs_rx_a: assert property (st_ff.sy2.act |=> O_CRS)
        else $error("no crs on receive");
    col_half_a: assert property (st_ff.cfg_dup |=> !O_COL)
        else $error("collision in full duplex");
    pin_dir_a: assert property (hw |=> !O_SPEED_SELECT_OE && !O_DUPLEX_SELECT_OE)
        else $error("pins driven in hw");
    fixed_link_a: assert property (hw && !st_ff.sy2.an
        |=> !O_AN_ENABLE && O_SPEED_SELECT == $past(st_ff.sy2.spd))
        else $error("fixed link wrong");
    par_half_a: assert property (nxt_st.cfg_an && !st_ff.sy2.pan |=> !O_DUPLEX_SELECT)
        else $error("duplex not half");
    link_lock_a: assert property (O_LINK_STATUS_OUT == $past(st_ff.sy2.link)
        && O_PLL_LOCK == $past(st_ff.sy2.lock))
        else $error("link or lock status lags");
    addr_tristate_a: assert property (st_ff.cap_done && st_ff.addr_cap == ADDR_TRISTATE
        |-> !O_RX_DATA_OE && !O_TX_CLK_OE && !O_RX_CLK_OE)
        else $error("driven at zero addr");

    frame_start_c: cover property (st_ff.tx_st == TX_K);
    rx_error_c: cover property ($rose(O_RX_ER));
    collision_c: cover property ($rose(O_COL));
    soft_mode_c: cover property (O_SPEED_SELECT_OE && O_SPEED_SELECT);

endmodule

// ---- test/pms_mac_model.sv ----
`timescale 1ns/1ps
module pms_mac_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tx_clk,
    input  wire logic       i_go,
    input  wire logic [4:0] i_len,
    input  wire logic [4:0] i_err_at,
    input  logic      [4:0] i_data [16],
    output logic            o_tx_en,
    output logic            o_tx_er,
    output logic      [4:0] o_tx_data,
    output logic            o_busy
);
    logic       clk_ff;
    logic [4:0] idx_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_ff    <= 1'h0;
            idx_ff    <= 5'h00;
            o_tx_en   <= 1'h0;
            o_tx_er   <= 1'h0;
            o_tx_data <= 5'h00;
            o_busy    <= 1'h0;
        end else begin
            clk_ff <= i_tx_clk;
            if (i_go) begin
                o_busy <= 1'h1;
                idx_ff <= 5'h00;
            end else if (i_tx_clk && !clk_ff) begin
                if (o_busy && idx_ff < i_len) begin
                    o_tx_en   <= 1'h1;
                    o_tx_er   <= (idx_ff == i_err_at);
                    o_tx_data <= i_data[idx_ff[3:0]];
                    idx_ff    <= idx_ff + 5'h01;
                end else begin
                    o_tx_en   <= 1'h0;
                    o_tx_er   <= 1'h0;
                    o_tx_data <= ~o_tx_data;
                    o_busy    <= 1'h0;
                end
            end
        end
    end
endmodule

// ---- test/pms_mac_side_bench.sv ----
`timescale 1ns/1ps
module pms_mac_side_bench;
    import pms_pkg::*;
    logic        clk = 1'h0, rst_n = 1'h0, go = 1'h0, rec = 1'h0, er_q = 1'h0;
    logic        ser = 1'h0, rep = 1'h0, hwsw = 1'h0, spd = 1'h1, dup = 1'h0, an = 1'h0;
    logic        pan = 1'h1, lclk = 1'h0, lact = 1'h0, link = 1'h0, lock = 1'h0;
    logic        rwr = 1'h0, rrd = 1'h0;
    logic [4:0]  addr = 5'h00, lsym = 5'h00, m_len = 5'h00, m_err = 5'h1F, s;
    logic [3:0]  ra = 4'h0;
    logic [7:0]  rwd = 8'h00, d;
    logic [31:0] r;
    logic [2:0]  kk;
    logic        s_o, s_oe, d_o, d_oe, a_o, a_oe, txc, txc_oe, rxc, rxc_oe, an_en;
    logic        rx_dv, rx_er, rx_oe, crs, col, link_o, lock_o, tx_en, tx_er, busy;
    logic [4:0]  rx_d, tsym, tx_d;
    logic [1:0]  an_adv;
    logic [7:0]  rdat;
    logic [4:0]  mdat [16];
    logic [4:0]  txq [$], expq [$], bad [$];
    int          error_cnt = 0, cmp_count = 0, er_cnt = 0, cyc = 0;

    pms_mac_side dut (
        .I_REF_CLK(clk), .I_RSTN(rst_n), .I_IFACE_SERIAL_SEL(ser), .I_REPEATER_SEL(rep),
        .I_HARDWARE_SOFTWARE_CONFIG_SELECT(hwsw), .I_PHY_ADDR(addr), .I_SPEED_SELECT(spd),
        .I_DUPLEX_SELECT(dup), .I_AUTONEG_SELECT(an), .O_SPEED_SELECT(s_o),
        .O_SPEED_SELECT_OE(s_oe), .O_DUPLEX_SELECT(d_o), .O_DUPLEX_SELECT_OE(d_oe),
        .O_AUTONEG_SELECT(a_o), .O_AUTONEG_SELECT_OE(a_oe), .O_TX_CLK(txc), .O_TX_CLK_OE(txc_oe),
        .O_RX_CLK(rxc), .O_RX_CLK_OE(rxc_oe), .I_TX_EN(tx_en), .I_TX_ER(tx_er), .I_TX_DATA(tx_d),
        .O_RX_DV(rx_dv), .O_RX_ER(rx_er), .O_RX_DATA(rx_d), .O_RX_DATA_OE(rx_oe), .O_CRS(crs),
        .O_COL(col), .I_LINE_CLK(lclk), .I_LINE_RX_SYM(lsym), .I_LINE_RX_ACT(lact),
        .I_LINE_LINK_OK(link), .I_LINE_PLL_LOCK(lock), .I_PARTNER_AN(pan), .O_LINE_TX_SYM(tsym),
        .O_LINE_TX_VALID(), .O_AN_ENABLE(an_en), .O_AN_ADVERTISE(an_adv), .O_LINK_STATUS_OUT(link_o),
        .O_PLL_LOCK(lock_o), .I_REG_ADDR(ra), .I_REG_WDATA(rwd), .I_REG_WR(rwr), .I_REG_RD(rrd),
        .O_REG_RDATA(rdat));

    pms_mac_model mac (.i_clk(clk), .i_rst_n(rst_n), .i_tx_clk(txc), .i_go(go), .i_len(m_len),
        .i_err_at(m_err), .i_data(mdat), .o_tx_en(tx_en), .o_tx_er(tx_er), .o_tx_data(tx_d),
        .o_busy(busy));

    always #25 clk = ~clk;

    always @(posedge txc) begin
        if (rec) begin
            txq.push_back(tsym);
        end
    end

    always @(posedge clk) begin
        er_q <= rx_er;
        if (rx_er === 1'h1 && er_q === 1'h0) begin
            er_cnt++;
        end
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [4:0] enc4(input logic [3:0] n);
        logic [4:0] t [16];
        t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
              5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
        return t[n];
    endfunction

    function automatic logic is_bad(input logic [4:0] c);
        logic hit;
        hit = (c == SYM_IDLE) || (c == SYM_J) || (c == SYM_K);
        hit = hit || (c == SYM_T) || (c == SYM_R) || (c == SYM_H);
        for (int n = 0; n < 16; n++) begin
            hit = hit || (enc4(4'(n)) == c);
        end
        return !hit;
    endfunction

    task automatic set_mode(input logic [6:0] m);
        @(posedge clk);
        {ser, rep, hwsw, spd, dup, an, pan} <= m;
        repeat (8) @(posedge clk);
    endtask

    task automatic do_reset(input logic [4:0] a);
        @(posedge clk);
        addr  <= a;
        rst_n <= 1'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        repeat (12) @(posedge clk);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        ra  <= a;
        rwd <= v;
        rwr <= 1'h1;
        @(posedge clk);
        rwr <= 1'h0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        ra  <= a;
        rrd <= 1'h1;
        @(posedge clk);
        rrd <= 1'h0;
        #1;
        v = rdat;
    endtask

    task automatic tx_run(input int n, input int e);
        txq = {};
        rec = 1'h1;
        @(posedge clk);
        m_len <= 5'(n);
        m_err <= 5'(e);
        go    <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
    endtask

    task automatic tx_end();
        for (int w = 0; w < 400 && busy === 1'h1; w++) begin
            @(posedge clk);
        end
        repeat (40) @(posedge clk);
        rec = 1'h0;
    endtask

    task automatic tx_cmp(input string what);
        int k;
        k = 0;
        while (k < txq.size() && txq[k] !== expq[0]) begin
            k++;
        end
        foreach (expq[i]) begin
            check(what, (k + i < txq.size()) ? 8'(txq[k + i]) : 8'hFF, 8'(expq[i]));
        end
    endtask

    task automatic rx_one(input logic [4:0] c, input logic [7:0] e, input logic [7:0] m);
        lsym = c;
        lclk = 1'h1;
        #200;
        lclk = 1'h0;
        #100;
        check("rx", {2'h0, rx_dv, rx_d} & m, e & m);
        #100;
    endtask

    task automatic period(input logic [7:0] half);
        time t0;
        @(posedge txc);
        t0 = $time;
        @(posedge txc);
        check("tx clk period", 8'(($time - t0) / 50), 8'(2 * half));
    endtask

    initial begin
        void'($urandom(32'hD444BF36));
        for (int c = 0; c < 32; c++) begin
            if (is_bad(5'(c))) begin
                bad.push_back(5'(c));
            end
        end
        check("bad codes", 8'(bad.size()), 8'h0A);
        do_reset(5'h00);
        check("oe at zero addr", {5'h0, txc_oe, rxc_oe, rx_oe}, 8'h00);
        r = $urandom;
        do_reset({1'h0, r[3:0]} + 5'h01);
        check("oe at addr", {5'h0, txc_oe, rxc_oe, rx_oe}, 8'h07);
        reg_rd(REG_CTRL, d);
        check("ctrl reset", d, CTRL_RST);
        reg_wr(REG_STAT, 8'h00);
        reg_rd(REG_CTRL, d);
        check("ctrl kept", d, CTRL_RST);
        reg_rd(4'h5, d);
        check("unmapped", d, 8'h00);
        for (int i = 0; i < 16; i++) begin
            r = 32'(i);
            set_mode({3'h0, r[3:0]});
            check("hw oe", {5'h0, s_oe, d_oe, a_oe}, 8'h00);
            check("hw cfg", {5'h0, s_o, d_o, a_o}, {5'h0, r[3], r[2] & (!r[1] | r[0]), r[1]});
            check("hw neg", {5'h0, an_en, r[1] ? an_adv : 2'h0}, {5'h0, r[1], r[1] ? r[3:2] : 2'h0});
        end
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            set_mode({3'h1, r[7:4]});
            reg_wr(REG_CTRL, {5'h0, r[2:0]});
            repeat (4) @(posedge clk);
            check("sw oe", {5'h0, s_oe, d_oe, a_oe}, 8'h07);
            check("sw cfg", {5'h0, s_o, d_o, a_o}, {5'h0, r[0], r[1] & (!r[2] | r[4]), r[2]});
            reg_rd(REG_CTRL, d);
            check("ctrl rd", d, {5'h0, r[2:0]});
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {link, lock} <= 2'(i);
            repeat (6) @(posedge clk);
            check("link", 8'(link_o), 8'(i[1]));
            check("lock", 8'(lock_o), 8'(i[0]));
        end
        set_mode(7'h09);
        period(HALF_100);
        set_mode(7'h01);
        period(HALF_M10);
        set_mode(7'h41);
        period(HALF_S10);
        set_mode(7'h49);
        mdat[0] = SYM_J;
        expq = {SYM_J};
        for (int i = 1; i < 6; i++) begin
            mdat[i] = 5'($urandom_range(30, 1));
            expq.push_back(mdat[i]);
        end
        tx_run(6, 2);
        tx_end();
        tx_cmp("stream tx");
        lact = 1'h1;
        #13;
        for (int i = 0; i < 4; i++) begin
            s = 5'($urandom);
            rx_one(s, {3'h0, s}, 8'h1F);
        end
        lact = 1'h0;
        for (int i = 0; i < 16; i++) begin
            mdat[i] = 5'h05;
        end
        for (int k = 0; k < 8; k++) begin
            kk = 3'(k);
            set_mode({1'h0, kk[2], 2'h1, kk[1], 2'h1});
            lact <= kk[0];
            tx_run(16, 31);
            repeat (12) @(posedge clk);
            check("crs tx", 8'(crs), kk[2] ? 8'(kk[0]) : 8'h01);
            check("col tx", 8'(col), 8'(!kk[1] && kk[0]));
            tx_end();
            check("crs idle", 8'(crs), 8'(kk[0]));
            check("col idle", 8'(col), 8'h00);
            lact <= 1'h0;
        end
        set_mode(7'h09);
        for (int f = 0; f < 2; f++) begin
            mdat[0] = 5'h05;
            mdat[1] = 5'h05;
            expq = {SYM_J, SYM_K};
            for (int i = 2; i < 10; i++) begin
                mdat[i] = 5'($urandom_range(15, 0));
                expq.push_back((i == 6 && f == 1) ? SYM_H : enc4(mdat[i][3:0]));
            end
            expq = {expq, SYM_T, SYM_R, SYM_IDLE};
            tx_run(10, (f == 1) ? 6 : 31);
            tx_end();
            tx_cmp("mii tx");
        end
        lact = 1'h1;
        #13;
        er_cnt = 0;
        rx_one(SYM_J, 8'h25, 8'h2F);
        rx_one(SYM_K, 8'h25, 8'h2F);
        foreach (bad[i]) begin
            s = 5'($urandom_range(15, 0));
            rx_one(enc4(s[3:0]), {4'h2, s[3:0]}, 8'h2F);
            rx_one(bad[i], 8'h20, 8'h20);
        end
        rx_one(SYM_T, 8'h00, 8'h20);
        lact = 1'h0;
        repeat (10) @(posedge clk);
        check("rx err pulses", 8'(er_cnt), 8'h0A);
        wrap_up();
    end
endmodule
